// [hw/sar_adc_params.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH

`define ADDR_CHANNEL_SELECT   8'hBB
`define ADDR_RESULT_LOW       8'hBE
`define ADDR_RESULT_HIGH      8'hBF
`define ADDR_CONV_CONTROL     8'hE8
`define ADDR_PAIR_CONFIG      8'hBA
`define ADDR_CLK_GAIN_CONFIG  8'hBC

`define RST_CHANNEL_SELECT    8'h00
`define RST_PAIR_CONFIG       8'h00
`define RST_CLK_GAIN_CONFIG   8'hF8
`define RST_CONV_CONTROL      8'h00
`define RST_RESULT            8'h00

`define CTL_ENABLE_BIT        3'd7
`define CTL_TRACK_BIT         3'd6
`define CTL_DONE_BIT          3'd5
`define CTL_BUSY_BIT          3'd4
`define CTL_MODE_HI           3'd3
`define CTL_MODE_LO           3'd2
`define CTL_WINDOW_BIT        3'd1
`define CTL_LJUST_BIT         3'd0

`define TRACK_SAR_CLOCKS      5'd3
`define CONV_SAR_CLOCKS       5'd16

`endif

// [hw/sar_adc_pkg.sv]
// Types shared by the converter control files
package sar_adc_pkg;
  typedef enum logic [1:0] {
    START_SOFTWARE,
    START_TIMER3,
    START_EXTERNAL,
    START_TIMER2
  } start_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRACK,
    ST_CONVERT
  } conv_state_t;
endpackage

// [hw/sar_clock_divider.sv]
// Divides the core clock into one-cycle SAR clock ticks
`timescale 1ns/10ps
`default_nettype none
module sar_clock_divider (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_run,
  input  wire logic [4:0] i_divider,
  output logic            o_tick
);
  typedef struct packed {
    logic [4:0] count;
    logic       tick;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!i_run) begin
      state_next.count = 5'h00;
    end else if (state_reg.count >= i_divider) begin
      state_next.count = 5'h00;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_tick = state_reg.tick;
endmodule
`default_nettype wire

// [hw/sar_adc_control_registers.sv]
// Control, configuration and result formatting for the SAR converter
//
// How it works
// - Upper nibble of pair-config and channel-select reads zero, writes ignored.
// - Each pair bit makes two inputs single-ended or one differential pair.
// - Differential channel results are presented in two's complement.
// - Codes 0-7 select input or pair; top bit set selects temperature sensor.
// - SAR clock equals core clock divided by divider field plus one.
// - Gain field 000=1,001=2,010=4,011=8,10x=16,11x=0.5 drives amplifier.
// - Enable bit 0 shuts converter down; 1 makes it active.
// - Track-mode 0 and enabled: track always except during conversion.
// - Done flag sets when busy falls at conversion end.
// - Hardware never clears done flag; software writes it to zero.
// - Busy reads 1 while tracking or converting after a start, 0 when idle.
// - Writing busy 0 does nothing; 1 starts only in start mode 00.
// - Start mode selects software, timer 3, external edge or timer 2.
// - Track-mode 1, modes 00/01/11: three SAR clocks tracking, then convert.
// - Track-mode 1, mode 10: track while external low, convert on rise.
// - Window flag set on match, cleared only by software.
// - Justify bit selects right (0) or left (1) justified result.
// - Right-justified high byte holds upper four bits, sign-filled above.
// - Sign fill only for differential readings; single-ended fills zero.
// - Left-justified high byte holds eight most significant result bits.
// - Low byte: lower eight bits right, lower four in 7:4 left.
// - A conversion lasts at least sixteen SAR clocks until busy falls.
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_params.svh"
module sar_adc_control_registers (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic [7:0]  i_sfr_wdata,
  input  wire logic        i_sfr_rd,
  input  wire logic        i_timer3_overflow,
  input  wire logic        i_timer2_overflow,
  input  wire logic        i_external_convert_start,
  input  wire logic        i_window_match,
  input  wire logic [11:0] i_sar_result,
  output logic [7:0]       o_sfr_rdata,
  output logic             o_converter_enable,
  output logic             o_track,
  output logic             o_sar_convert,
  output logic             o_sar_clock_tick,
  output logic [3:0]       o_mux_select,
  output logic             o_mux_differential,
  output logic             o_mux_temp_sensor,
  output logic [2:0]       o_amplifier_gain_code
);

  //////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [3:0]                channel_select_code;
    logic [3:0]                pair_differential;
    logic [4:0]                sar_clock_divider;
    logic [2:0]                amplifier_gain_code;
    logic                      converter_enable;
    logic                      track_mode_select;
    logic                      conversion_done_flag;
    sar_adc_pkg::start_mode_t  start_mode_select;
    logic                      window_match_flag;
    logic                      left_justify_select;
    sar_adc_pkg::conv_state_t  conv_state;
    logic [4:0]                sar_count;
    logic                      ext_prev;
    logic                      conv_diff;
    logic [7:0]                result_high;
    logic [7:0]                result_low;
    logic [7:0]                rdata;
    logic                      track;
    logic                      convert;
    logic [3:0]                mux_select;
    logic                      mux_diff;
    logic                      mux_temp;
  } ctl_state_t;

  ctl_state_t state_reg;
  ctl_state_t state_next;
  logic       sar_tick;
  logic       div_run;

  // Reset images of the registers, split into fields in the reset branch
  localparam logic [7:0] ch_reset   = `RST_CHANNEL_SELECT;
  localparam logic [7:0] pair_reset = `RST_PAIR_CONFIG;
  localparam logic [7:0] cfg_reset  = `RST_CLK_GAIN_CONFIG;
  localparam logic [7:0] ctl_reset  = `RST_CONV_CONTROL;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  // Maps a channel code onto the mux: either member of a differential pair goes to the pair's even select
  function automatic logic [5:0] route_channel(input logic [3:0] code,
                                               input logic [3:0] pairs);
    logic [3:0] sel;
    logic       diff;
    logic       temp;
    sel  = code;
    diff = 1'b0;
    temp = code[3];
    if (!code[3] && pairs[code[2:1]]) begin
      sel  = {code[3:1], 1'b0};
      diff = 1'b1;
    end
    return {sel, diff, temp};
  endfunction

  function automatic logic [7:0] control_byte(input ctl_state_t s);
    logic busy;
    busy = (s.conv_state != sar_adc_pkg::ST_IDLE);
    return {s.converter_enable, s.track_mode_select, s.conversion_done_flag,
            busy, s.start_mode_select, s.window_match_flag,
            s.left_justify_select};
  endfunction

  // Register decode shared by the write and read paths
  // One bit per mapped register; unmapped addresses give all zero
  function automatic logic [5:0] reg_select(input logic [7:0] addr);
    logic [5:0] sel_bits;
    sel_bits    = 6'h00;
    sel_bits[0] = (addr == `ADDR_CHANNEL_SELECT);
    sel_bits[1] = (addr == `ADDR_PAIR_CONFIG);
    sel_bits[2] = (addr == `ADDR_CLK_GAIN_CONFIG);
    sel_bits[3] = (addr == `ADDR_CONV_CONTROL);
    sel_bits[4] = (addr == `ADDR_RESULT_HIGH);
    sel_bits[5] = (addr == `ADDR_RESULT_LOW);
    return sel_bits;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // SAR clock

  sar_clock_divider u_divider (
    .i_clk     (i_clk),
    .i_srst    (i_srst),
    .i_run     (div_run),
    .i_divider (state_reg.sar_clock_divider),
    .o_tick    (sar_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state

  logic       wr_ctl;
  logic       sw_start;
  logic       ext_rise;
  logic       trigger;
  logic [5:0] route;
  logic [11:0] res;
  logic [5:0] reg_hit;

  always_comb begin
    state_next = state_reg;
    reg_hit  = reg_select(i_sfr_addr);
    wr_ctl   = i_sfr_wr && reg_hit[3];
    sw_start = wr_ctl && i_sfr_wdata[`CTL_BUSY_BIT];
    ext_rise = i_external_convert_start && !state_reg.ext_prev;
    route    = route_channel(state_reg.channel_select_code,
                             state_reg.pair_differential);
    res      = i_sar_result;
    state_next.ext_prev = i_external_convert_start;

    case (state_reg.start_mode_select)
      sar_adc_pkg::START_SOFTWARE: trigger = sw_start;
      sar_adc_pkg::START_TIMER3:   trigger = i_timer3_overflow;
      sar_adc_pkg::START_EXTERNAL: trigger = ext_rise;
      sar_adc_pkg::START_TIMER2:   trigger = i_timer2_overflow;
      default:                     trigger = 1'b0;
    endcase

    // Restart the SAR clock on an accepted start so every period is full
    div_run = state_reg.converter_enable &&
              !(state_reg.conv_state == sar_adc_pkg::ST_IDLE && trigger);

    // Register writes; busy is not stored, writing it only triggers
    if (i_sfr_wr && reg_hit[0]) begin
      state_next.channel_select_code = i_sfr_wdata[3:0];
    end
    if (i_sfr_wr && reg_hit[1]) begin
      state_next.pair_differential = i_sfr_wdata[3:0];
    end
    if (i_sfr_wr && reg_hit[2]) begin
      state_next.sar_clock_divider   = i_sfr_wdata[7:3];
      state_next.amplifier_gain_code = i_sfr_wdata[2:0];
    end
    if (wr_ctl) begin
      state_next.converter_enable     = i_sfr_wdata[`CTL_ENABLE_BIT];
      state_next.track_mode_select    = i_sfr_wdata[`CTL_TRACK_BIT];
      state_next.conversion_done_flag = i_sfr_wdata[`CTL_DONE_BIT];
      state_next.start_mode_select    =
        sar_adc_pkg::start_mode_t'(i_sfr_wdata[`CTL_MODE_HI:`CTL_MODE_LO]);
      state_next.window_match_flag    = i_sfr_wdata[`CTL_WINDOW_BIT];
      state_next.left_justify_select  = i_sfr_wdata[`CTL_LJUST_BIT];
    end
    if (i_sfr_wr && reg_hit[4]) begin
      state_next.result_high = i_sfr_wdata;
    end
    if (i_sfr_wr && reg_hit[5]) begin
      state_next.result_low = i_sfr_wdata;
    end

    // Hardware only sets the window flag; set wins over a clearing write
    if (i_window_match) begin
      state_next.window_match_flag = 1'b1;
    end

    case (state_reg.conv_state)
      sar_adc_pkg::ST_IDLE: begin
        // Disabled converter ignores triggers
        if (state_reg.converter_enable && trigger) begin
          state_next.sar_count = 5'h00;
          state_next.conv_diff = route[1];
          if (state_reg.track_mode_select &&
              state_reg.start_mode_select != sar_adc_pkg::START_EXTERNAL) begin
            state_next.conv_state = sar_adc_pkg::ST_TRACK;
          end else begin
            state_next.conv_state = sar_adc_pkg::ST_CONVERT;
          end
        end
      end
      sar_adc_pkg::ST_TRACK: begin
        if (!state_reg.converter_enable) begin
          state_next.conv_state = sar_adc_pkg::ST_IDLE;
        end else if (sar_tick) begin
          if (state_reg.sar_count == `TRACK_SAR_CLOCKS - 5'd1) begin
            state_next.sar_count  = 5'h00;
            state_next.conv_state = sar_adc_pkg::ST_CONVERT;
          end else begin
            state_next.sar_count = state_reg.sar_count + 5'h01;
          end
        end
      end
      sar_adc_pkg::ST_CONVERT: begin
        // Triggers during a conversion are dropped
        if (!state_reg.converter_enable) begin
          state_next.conv_state = sar_adc_pkg::ST_IDLE;
        end else if (sar_tick) begin
          if (state_reg.sar_count == `CONV_SAR_CLOCKS - 5'd1) begin
            state_next.conv_state = sar_adc_pkg::ST_IDLE;
            state_next.conversion_done_flag = 1'b1;
            if (state_reg.left_justify_select) begin
              state_next.result_high = res[11:4];
              state_next.result_low  = {res[3:0], 4'h0};
            end else begin
              state_next.result_high = {{4{state_reg.conv_diff & res[11]}},
                                        res[11:8]};
              state_next.result_low  = res[7:0];
            end
          end else begin
            state_next.sar_count = state_reg.sar_count + 5'h01;
          end
        end
      end
      default: state_next.conv_state = sar_adc_pkg::ST_IDLE;
    endcase

    // Analog controls
    state_next.track = 1'b0;
    if (state_reg.converter_enable) begin
      if (!state_reg.track_mode_select) begin
        state_next.track =
          (state_next.conv_state != sar_adc_pkg::ST_CONVERT);
      end else if (state_reg.start_mode_select ==
                   sar_adc_pkg::START_EXTERNAL) begin
        state_next.track = !i_external_convert_start &&
          (state_next.conv_state != sar_adc_pkg::ST_CONVERT);
      end else begin
        state_next.track =
          (state_next.conv_state == sar_adc_pkg::ST_TRACK);
      end
    end
    state_next.convert    = (state_next.conv_state == sar_adc_pkg::ST_CONVERT);
    state_next.mux_select = route[5:2];
    state_next.mux_diff   = route[1];
    state_next.mux_temp   = route[0];

    // Read data registered one cycle after the read strobe
    state_next.rdata = 8'h00;
    if (i_sfr_rd && reg_hit[0]) begin
      state_next.rdata = {4'h0, state_reg.channel_select_code};
    end
    if (i_sfr_rd && reg_hit[1]) begin
      state_next.rdata = {4'h0, state_reg.pair_differential};
    end
    if (i_sfr_rd && reg_hit[2]) begin
      state_next.rdata = {state_reg.sar_clock_divider,
                          state_reg.amplifier_gain_code};
    end
    if (i_sfr_rd && reg_hit[3]) begin
      state_next.rdata = control_byte(state_reg);
    end
    if (i_sfr_rd && reg_hit[4]) begin
      state_next.rdata = state_reg.result_high;
    end
    if (i_sfr_rd && reg_hit[5]) begin
      state_next.rdata = state_reg.result_low;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= '0;
      state_reg.channel_select_code <= ch_reset[3:0];
      state_reg.pair_differential   <= pair_reset[3:0];
      state_reg.sar_clock_divider   <= cfg_reset[7:3];
      state_reg.amplifier_gain_code <= cfg_reset[2:0];
      state_reg.converter_enable     <= ctl_reset[`CTL_ENABLE_BIT];
      state_reg.track_mode_select    <= ctl_reset[`CTL_TRACK_BIT];
      state_reg.conversion_done_flag <= ctl_reset[`CTL_DONE_BIT];
      state_reg.start_mode_select    <= sar_adc_pkg::start_mode_t'(
        ctl_reset[`CTL_MODE_HI:`CTL_MODE_LO]);
      state_reg.window_match_flag    <= ctl_reset[`CTL_WINDOW_BIT];
      state_reg.left_justify_select  <= ctl_reset[`CTL_LJUST_BIT];
      state_reg.conv_state          <= sar_adc_pkg::ST_IDLE;
      state_reg.result_high         <= `RST_RESULT;
      state_reg.result_low          <= `RST_RESULT;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_sfr_rdata           = state_reg.rdata;
  assign o_converter_enable    = state_reg.converter_enable;
  assign o_track               = state_reg.track;
  assign o_sar_convert         = state_reg.convert;
  assign o_sar_clock_tick      = sar_tick;
  assign o_mux_select          = state_reg.mux_select;
  assign o_mux_differential    = state_reg.mux_diff;
  assign o_mux_temp_sensor     = state_reg.mux_temp;
  assign o_amplifier_gain_code = state_reg.amplifier_gain_code;
endmodule
`default_nettype wire

// [sim/sar_adc_control_registers_assertions.sv]
// Port-level checks for the converter control registers
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_params.svh"
module sar_adc_control_registers_assertions (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_sfr_wr,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic        o_converter_enable,
  input wire logic        o_track,
  input wire logic        o_sar_convert,
  input wire logic        o_sar_clock_tick,
  input wire logic [3:0]  o_mux_select,
  input wire logic        o_mux_differential,
  input wire logic        o_mux_temp_sensor,
  input wire logic [2:0]  o_amplifier_gain_code
);
  logic [4:0] tick_cnt_reg;
  // Counts SAR ticks seen while a conversion is running
  always_ff @(posedge i_clk) begin
    if (i_srst || !o_sar_convert)
      tick_cnt_reg <= 5'h00;
    else if (o_sar_clock_tick && tick_cnt_reg != 5'h1F)
      tick_cnt_reg <= tick_cnt_reg + 5'h01;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_cfg_nibble;
    $past(i_sfr_rd && (i_sfr_addr == `ADDR_PAIR_CONFIG ||
      i_sfr_addr == `ADDR_CHANNEL_SELECT)) |-> o_sfr_rdata[7:4] == 4'h0;
  endproperty
  a_cfg_nibble: assert property (p_cfg_nibble)
    else $error("upper config nibble not zero");
  property p_temp_sel;
    $past(i_sfr_wr && i_sfr_addr == `ADDR_CHANNEL_SELECT, 2)
      |-> o_mux_temp_sensor == $past(i_sfr_wdata[3], 2);
  endproperty
  a_temp_sel: assert property (p_temp_sel)
    else $error("temperature select wrong");
  property p_diff_even;
    o_mux_differential |-> !o_mux_select[0] && !o_mux_temp_sensor;
  endproperty
  a_diff_even: assert property (p_diff_even)
    else $error("pair select not even");
  property p_gain_wr;
    $past(i_sfr_wr && i_sfr_addr == `ADDR_CLK_GAIN_CONFIG)
      |-> o_amplifier_gain_code == $past(i_sfr_wdata[2:0]);
  endproperty
  a_gain_wr: assert property (p_gain_wr)
    else $error("gain code not loaded");
  property p_gain_hold;
    !$past(i_sfr_wr && i_sfr_addr == `ADDR_CLK_GAIN_CONFIG)
      |-> $stable(o_amplifier_gain_code);
  endproperty
  a_gain_hold: assert property (p_gain_hold)
    else $error("gain code changed unasked");
  property p_enable_wr;
    $past(i_sfr_wr && i_sfr_addr == `ADDR_CONV_CONTROL)
      |-> o_converter_enable == $past(i_sfr_wdata[7]);
  endproperty
  a_enable_wr: assert property (p_enable_wr)
    else $error("enable not loaded");
  property p_off_idle;
    !o_converter_enable && !$past(o_converter_enable) |-> !o_sar_convert;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("converting while shut down");
  property p_conv_start;
    $rose(o_sar_convert) |-> o_converter_enable;
  endproperty
  a_conv_start: assert property (p_conv_start)
    else $error("conversion started while disabled");
  property p_track_excl;
    o_sar_convert |-> !o_track;
  endproperty
  a_track_excl: assert property (p_track_excl)
    else $error("tracking during conversion");
  property p_conv_len;
    $fell(o_sar_convert) && o_converter_enable |-> tick_cnt_reg >= 5'd16;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion too short");
endmodule

bind sar_adc_control_registers sar_adc_control_registers_assertions i_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd),
  .o_sfr_rdata(o_sfr_rdata), .o_converter_enable(o_converter_enable),
  .o_track(o_track), .o_sar_convert(o_sar_convert),
  .o_sar_clock_tick(o_sar_clock_tick), .o_mux_select(o_mux_select),
  .o_mux_differential(o_mux_differential),
  .o_mux_temp_sensor(o_mux_temp_sensor),
  .o_amplifier_gain_code(o_amplifier_gain_code));
`default_nettype wire

// [sim/sar_sfr_host.sv]
// Processor-side model driving the special function register bus
`timescale 1ns/10ps
`default_nettype none
module sar_sfr_host (
  input  wire logic       i_clk,
  output logic [7:0]      o_addr,
  output logic            o_wr,
  output logic [7:0]      o_wdata,
  output logic            o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end
  // Released lines show the inverse so stale values never pass
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// [sim/tb_sar_adc_control_registers.sv]
// Self-checking bench for the converter control registers
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_params.svh"
module tb_sar_adc_control_registers;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        t3 = 1'b0;
  logic        t2 = 1'b0;
  logic        ext = 1'b0;
  logic        win = 1'b0;
  logic [11:0] res = 12'h000;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        sfr_wr;
  logic        sfr_rd;
  logic        en;
  logic        trk;
  logic        conv;
  logic        tick;
  logic [3:0]  msel;
  logic        mdif;
  logic        mtmp;
  logic [2:0]  gain;
  logic        rd_seen = 1'b0;
  logic [7:0]  exp_q[$];
  int          failures = 0;
  int          compares = 0;
  always #2.5 clk = ~clk;
  sar_sfr_host i_host (.i_clk(clk), .o_addr(addr), .o_wr(sfr_wr),
    .o_wdata(wdata), .o_rd(sfr_rd));
  sar_adc_control_registers i_dut (.i_clk(clk), .i_srst(srst),
    .i_sfr_addr(addr), .i_sfr_wr(sfr_wr), .i_sfr_wdata(wdata),
    .i_sfr_rd(sfr_rd), .i_timer3_overflow(t3), .i_timer2_overflow(t2),
    .i_external_convert_start(ext), .i_window_match(win),
    .i_sar_result(res), .o_sfr_rdata(rdata), .o_converter_enable(en),
    .o_track(trk), .o_sar_convert(conv), .o_sar_clock_tick(tick),
    .o_mux_select(msel), .o_mux_differential(mdif),
    .o_mux_temp_sensor(mtmp), .o_amplifier_gain_code(gain));
  ////////////////////////////////////////////////////////////////////
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.rd_reg(a);
  endtask
  // Read data is valid the cycle after the read strobe is taken
  always @(posedge clk) begin
    if (rd_seen)
      chk_out({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    rd_seen <= sfr_rd;
  end
  task automatic wait_done;
    int n;
    n = 0;
    while (conv !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk_out({15'h0, conv}, 16'h1);
    while (conv !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk_out({15'h0, conv}, 16'h0);
  endtask
  task automatic conv_case(input logic [3:0] cfg, input logic [3:0] ch,
                           input logic lj);
    logic        dif;
    logic [11:0] r;
    logic [15:0] f;
    logic [15:0] m;
    dif = !ch[3] && cfg[ch[2:1]];
    m = {9'h0, (dif ? {ch[3:1], 1'b0} : ch), 1'b1, dif, ch[3]};
    r = 12'($urandom) | 12'h800;
    res <= r;
    f = lj ? {r, 4'h0} : {(dif ? 4'hF : 4'h0), r};
    i_host.wr_reg(`ADDR_PAIR_CONFIG, {4'hA, cfg});
    i_host.wr_reg(`ADDR_CHANNEL_SELECT, {4'h5, ch});
    i_host.wr_reg(`ADDR_CONV_CONTROL, {7'h40, lj});
    repeat (2) @(negedge clk);
    chk_out({9'h0, msel, trk, mdif, mtmp}, m);
    i_host.wr_reg(`ADDR_CONV_CONTROL, {7'h48, lj});
    wait_done;
    rd(`ADDR_CONV_CONTROL, {7'h50, lj});
    rd(`ADDR_CONV_CONTROL, {7'h50, lj});
    rd(`ADDR_RESULT_HIGH, f[15:8]);
    rd(`ADDR_RESULT_LOW, f[7:0]);
    i_host.wr_reg(`ADDR_CONV_CONTROL, {7'h40, lj});
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    failures++;
    finish_test;
  end
  initial begin
    void'($urandom(24));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(`ADDR_CHANNEL_SELECT, 8'h00);
    rd(`ADDR_PAIR_CONFIG, 8'h00);
    rd(`ADDR_CLK_GAIN_CONFIG, 8'hF8);
    rd(`ADDR_CONV_CONTROL, 8'h00);
    rd(`ADDR_RESULT_HIGH, 8'h00);
    rd(8'h10, 8'h00);
    i_host.wr_reg(`ADDR_CHANNEL_SELECT, 8'hFF);
    rd(`ADDR_CHANNEL_SELECT, 8'h0F);
    i_host.wr_reg(`ADDR_PAIR_CONFIG, 8'hF5);
    rd(`ADDR_PAIR_CONFIG, 8'h05);
    $display("test reset_and_unused done");
    for (int g = 0; g < 8; g++) begin
      i_host.wr_reg(`ADDR_CLK_GAIN_CONFIG, {5'd1, 3'(g)});
      @(negedge clk);
      chk_out({13'h0, gain}, 16'(g));
    end
    rd(`ADDR_CLK_GAIN_CONFIG, 8'h0F);
    $display("test gain_codes done");
    i_host.wr_reg(`ADDR_CONV_CONTROL, 8'h10);
    repeat (20) @(posedge clk);
    chk_out({15'h0, conv}, 16'h0);
    win <= 1'b1;
    @(posedge clk);
    win <= 1'b0;
    rd(`ADDR_CONV_CONTROL, 8'h02);
    rd(`ADDR_CONV_CONTROL, 8'h02);
    i_host.wr_reg(`ADDR_CONV_CONTROL, 8'h00);
    rd(`ADDR_CONV_CONTROL, 8'h00);
    $display("test disabled_and_window done");
    conv_case(4'h0, 4'h2, 1'b0);
    conv_case(4'h1, 4'h1, 1'b0);
    conv_case(4'h8, 4'h6, 1'b1);
    conv_case(4'hF, 4'h9, 1'b0);
    conv_case(4'h0, 4'h7, 1'b1);
    $display("test conversions done");
    for (int m = 1; m < 4; m++) begin
      i_host.wr_reg(`ADDR_CONV_CONTROL, {4'h8, 2'(m), 2'b00});
      i_host.wr_reg(`ADDR_CONV_CONTROL, {4'h9, 2'(m), 2'b00});
      repeat (20) @(posedge clk);
      chk_out({15'h0, conv}, 16'h0);
      t3 <= (m == 1);
      t2 <= (m == 3);
      ext <= (m == 2);
      @(posedge clk);
      t3 <= 1'b0;
      t2 <= 1'b0;
      wait_done;
      ext <= 1'b0;
      rd(`ADDR_CONV_CONTROL, {4'hA, 2'(m), 2'b00});
      i_host.wr_reg(`ADDR_CONV_CONTROL, 8'h80);
    end
    $display("test start_modes done");
    i_host.wr_reg(`ADDR_CONV_CONTROL, 8'hC0);
    i_host.wr_reg(`ADDR_CONV_CONTROL, 8'hD0);
    repeat (3) @(negedge clk);
    chk_out({14'h0, trk, conv}, 16'h2);
    wait_done;
    rd(`ADDR_CONV_CONTROL, 8'hE0);
    i_host.wr_reg(`ADDR_CONV_CONTROL, 8'hC8);
    repeat (4) @(negedge clk);
    chk_out({14'h0, trk, conv}, 16'h2);
    @(posedge clk);
    ext <= 1'b1;
    wait_done;
    rd(`ADDR_CONV_CONTROL, 8'hE8);
    $display("test track_mode done");
    repeat (4) @(posedge clk);
    finish_test;
  end
endmodule
`default_nettype wire
